// ---- rtl/mps_core.sv ----
// addressing core: return stack, program paging, table pointer, data
// bank and page selection, accumulator and flag-keeping unit
// assumes one operation per cycle on i_op from same-clock decode logic
// and a table ROM that answers i_table_data from o_table_addr at once
//
// Functional notes
// RULE1 - sixteen-deep last-in-first-out stack, each entry 49 bits
// RULE2 - calls and interrupt entries push the program counter automatically
// RULE3 - return pops the top entry back into the program counter
// RULE4 - beyond sixteen pushes the oldest entry is lost, no overflow flag
// RULE5 - 16384-word program space, eight 2048-word pages, 14-bit address
// RULE6 - jump and call take their page from the program page register
// RULE7 - conditional branches and skips never change the page bits
// RULE8 - table read fetches one nibble at the 16-bit lookup index
// RULE9 - lookup index is four nibbles, each loaded by its own operation
// RULE10 - 3-bit page code selects a 2048-word window, 111 is 3800H-3FFFH
// RULE11 - 2048-nibble RAM in sixteen 128-nibble banks chosen by bank reg
// RULE12 - bank value n starts the data range at n times 80H
// RULE13 - indirect page low bits pick a 16-nibble page; bit 3 reserved
// RULE14 - first two banks double as sixteen pages of working registers
// RULE15 - scratch page value n maps working registers to n times 10H
// RULE16 - immediate operands only combine with working registers
// RULE17 - 4-bit accumulator holds results and carries transfers
// RULE18 - unit does AND XOR OR, rotates, shifts, add sub inc dec
// RULE19 - carry and zero flags kept after each operation; carry readable
// RULE20 - branch tests: bits 0-3, zero, carry, and decrement-then-skip
// RULE21 - jump address is selected page above the 11-bit offset
module mps_core
  import mps_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_reset,
  input wire mps_op_t i_op,
  input wire mps_cond_t i_cond,
  input wire logic [MPS_NIB_W-1:0] i_operand,
  input wire logic [MPS_NIB_W-1:0] i_imm,
  input wire logic i_use_imm,
  input wire logic i_operand_is_wr,
  input wire logic [MPS_OFS_W-1:0] i_offset,
  input wire logic [MPS_PC_W-1:0] i_vector,
  input wire logic [MPS_CTX_W-1:0] i_context,
  input wire logic [MPS_NIB_W-1:0] i_table_data,
  output logic [MPS_PC_W-1:0] o_pc,
  output logic [MPS_CTX_W-1:0] o_pop_context,
  output logic [MPS_NIB_W-1:0] o_program_page_reg,
  output logic [MPS_NIB_W-1:0] o_indirect_page_reg,
  output logic [MPS_NIB_W-1:0] o_scratch_page_reg,
  output logic [MPS_NIB_W-1:0] o_ram_bank_reg,
  output logic [MPS_NIB_W-1:0] o_acc,
  output logic o_carry_flag,
  output logic o_zero_flag,
  output logic [MPS_TAB_W-1:0] o_table_addr,
  output logic [MPS_RAM_ADDR_W-1:0] o_bank_base,
  output logic [MPS_RAM_ADDR_W-1:0] o_indirect_base,
  output logic [MPS_WR_ADDR_W-1:0] o_wr_base,
  output logic [MPS_NIB_W-1:0] o_result,
  output logic o_result_valid,
  output logic o_illegal
);

  // advance within the current page, leaving the page bits alone
  function automatic logic [MPS_PC_W-1:0] page_step(
    input logic [MPS_PC_W-1:0] pc, input logic [MPS_OFS_W-1:0] n);
    logic [MPS_OFS_W-1:0] ofs;
    ofs = pc[MPS_OFS_W-1:0] + n;
    return {pc[MPS_PC_W-1:MPS_OFS_W], ofs};
  endfunction

  // immediate-or-operand source selection, shared by loads and the alu
  function automatic logic [MPS_NIB_W-1:0] pick_src(
    input logic use_imm, input logic [MPS_NIB_W-1:0] imm,
    input logic [MPS_NIB_W-1:0] opnd);
    return use_imm ? imm : opnd;
  endfunction

  // stack storage and pointer to the next free slot
  logic [MPS_STACK_W-1:0] stack_mem [MPS_STACK_DEPTH];
  logic [MPS_PTR_W-1:0] stack_ptr;
  logic [MPS_NIB_W-1:0] tab_nib [4];
  logic [MPS_PC_W-1:0] next_pc;
  logic [MPS_NIB_W-1:0] next_acc;
  logic next_carry;
  logic next_zero;
  logic next_result_valid;
  logic [MPS_NIB_W-1:0] next_result;

  // operand decode; alu ops and accumulator loads refuse immediates unless aimed at a working reg
  wire logic imm_refused = i_use_imm && !i_operand_is_wr; // RULE16
  wire logic [MPS_NIB_W-1:0] src =
    pick_src(i_use_imm, i_imm, i_operand);
  wire logic is_alu = (i_op >= MPS_OP_AND) && (i_op <= MPS_OP_SHLC);
  wire logic is_load_reg = (i_op >= MPS_OP_LOAD_PROG_PAGE) &&
    (i_op <= MPS_OP_LOAD_BANK);
  wire logic is_load_tab = (i_op >= MPS_OP_LOAD_TAB0) &&
    (i_op <= MPS_OP_LOAD_TAB3);
  wire logic refuse = imm_refused && (is_alu || i_op == MPS_OP_LOAD_ACC);
  wire logic tab_refused = is_load_tab && i_use_imm; // RULE9
  wire logic is_branch = (i_op == MPS_OP_BRANCH_JUMP) ||
    (i_op == MPS_OP_BRANCH_SKIP);

  // stack read and write slots
  wire logic [MPS_PTR_W-1:0] top_idx = stack_ptr - 4'h1;
  wire logic [MPS_STACK_W-1:0] top_entry = stack_mem[top_idx];
  wire logic [MPS_PC_W-1:0] ret_pc = page_step(o_pc, MPS_STEP_ONE);
  wire logic do_push = (i_op == MPS_OP_CALL) ||
    (i_op == MPS_OP_INT_ENTRY); // RULE2
  // a call resumes after itself, an interrupt at the interrupted word
  wire logic [MPS_PC_W-1:0] push_pc =
    (i_op == MPS_OP_CALL) ? ret_pc : o_pc; // RULE2
  wire logic do_pop = (i_op == MPS_OP_RETURN); // RULE3

  // far target: selected page above the in-page offset
  wire logic [MPS_PAGE_W-1:0] target_page =
    o_program_page_reg[MPS_PAGE_W-1:0]; // RULE6 RULE10
  wire logic [MPS_PC_W-1:0] far_target = {target_page, i_offset}; // RULE21
  // near target keeps the page where the branch sits
  wire logic [MPS_PC_W-1:0] near_target =
    {o_pc[MPS_PC_W-1:MPS_OFS_W], i_offset}; // RULE7

  // decrement used by the decrement-then-skip tests
  wire logic [MPS_NIB_W:0] dec_wide = {1'b0, i_operand} - 5'h01;
  wire logic [MPS_NIB_W-1:0] dec_val = dec_wide[MPS_NIB_W-1:0];
  wire logic dec_is_zero = (dec_val == 4'h0);

  // branch condition evaluation
  logic cond_true;
  always_comb begin
    case (i_cond)
      MPS_C_BIT0: cond_true = i_operand[0]; // RULE20
      MPS_C_BIT1: cond_true = i_operand[1];
      MPS_C_BIT2: cond_true = i_operand[2];
      MPS_C_BIT3: cond_true = i_operand[3];
      MPS_C_ZERO: cond_true = o_zero_flag;
      MPS_C_NONZERO: cond_true = !o_zero_flag;
      MPS_C_CARRY: cond_true = o_carry_flag;
      MPS_C_NOCARRY: cond_true = !o_carry_flag;
      MPS_C_DEC_ZERO: cond_true = dec_is_zero; // RULE20
      MPS_C_DEC_NONZERO: cond_true = !dec_is_zero;
      default: cond_true = 1'b0;
    endcase
  end
  wire logic is_dec_cond = (i_cond == MPS_C_DEC_ZERO) ||
    (i_cond == MPS_C_DEC_NONZERO);

  // program counter selection
  always_comb begin
    next_pc = page_step(o_pc, MPS_STEP_ONE);
    case (i_op)
      MPS_OP_IDLE: next_pc = o_pc;
      MPS_OP_JUMP: next_pc = far_target; // RULE5 RULE6
      MPS_OP_CALL: next_pc = far_target; // RULE6
      MPS_OP_INT_ENTRY: next_pc = i_vector;
      MPS_OP_RETURN: next_pc = top_entry[MPS_PC_W-1:0]; // RULE3
      MPS_OP_BRANCH_JUMP: begin
        if (cond_true) begin
          next_pc = near_target; // RULE7
        end
      end
      MPS_OP_BRANCH_SKIP: begin
        if (cond_true) begin
          next_pc = page_step(o_pc, MPS_STEP_TWO); // RULE7
        end
      end
      default: next_pc = page_step(o_pc, MPS_STEP_ONE);
    endcase
  end

  // arithmetic and logic on accumulator and source operand
  logic [MPS_NIB_W:0] sum;
  always_comb begin
    sum = 5'h00;
    next_acc = o_acc;
    next_carry = o_carry_flag;
    next_zero = o_zero_flag;
    next_result = o_result;
    next_result_valid = 1'b0;
    case (i_op)
      MPS_OP_AND: sum = {o_carry_flag, o_acc & src}; // RULE18
      MPS_OP_XOR: sum = {o_carry_flag, o_acc ^ src};
      MPS_OP_OR: sum = {o_carry_flag, o_acc | src};
      MPS_OP_ADD: sum = {1'b0, o_acc} + {1'b0, src};
      MPS_OP_ADC: sum = {1'b0, o_acc} + {1'b0, src} + {4'h0, o_carry_flag};
      // carry set means no borrow
      MPS_OP_SUB: sum = {1'b1, o_acc} - {1'b0, src};
      MPS_OP_SBC: sum = {1'b1, o_acc} - {1'b0, src} - {4'h0, !o_carry_flag};
      MPS_OP_INC: sum = {1'b0, src} + 5'h01;
      MPS_OP_DEC: sum = {1'b1, src} - 5'h01;
      MPS_OP_RRC: sum = {src[0], o_carry_flag, src[3:1]};
      MPS_OP_RLC: sum = {src[3], src[2:0], o_carry_flag};
      MPS_OP_SHRC: sum = {src[0], 1'b0, src[3:1]};
      MPS_OP_SHLC: sum = {src[3], src[2:0], 1'b0};
      default: sum = 5'h00;
    endcase
    if (is_alu && !refuse) begin
      next_acc = sum[MPS_NIB_W-1:0]; // RULE17
      next_carry = sum[MPS_NIB_W]; // RULE19
      next_zero = (sum[MPS_NIB_W-1:0] == 4'h0); // RULE19
      next_result = sum[MPS_NIB_W-1:0];
      next_result_valid = 1'b1;
    end else if (i_op == MPS_OP_LOAD_ACC && !refuse) begin
      next_acc = src; // RULE17
      next_zero = (src == 4'h0);
    end else if (is_branch && is_dec_cond) begin
      // the decremented value goes back to its register via o_result
      next_result = dec_val; // RULE20
      next_result_valid = 1'b1;
      next_carry = !dec_wide[MPS_NIB_W]; // RULE19
      next_zero = dec_is_zero; // RULE19
    end else if (i_op == MPS_OP_TABLE_READ) begin
      next_result = i_table_data; // RULE8
      next_result_valid = 1'b1;
    end else if (i_op == MPS_OP_READ_CARRY) begin
      next_result = {3'h0, o_carry_flag}; // RULE19
      next_result_valid = 1'b1;
    end
  end

  // bases of the data windows derived from the selection registers
  logic [MPS_NIB_W-1:0] next_bank;
  logic [MPS_NIB_W-1:0] next_ind;
  logic [MPS_NIB_W-1:0] next_scratch;
  wire logic [MPS_RAM_ADDR_W-1:0] next_bank_base =
    {next_bank, 7'h00}; // RULE11 RULE12
  wire logic [MPS_RAM_ADDR_W-1:0] next_ind_base =
    {next_bank, next_ind[MPS_IND_SEL_W-1:0], 4'h0}; // RULE13
  wire logic [MPS_WR_ADDR_W-1:0] next_wr_base =
    {next_scratch, 4'h0}; // RULE14 RULE15
  assign next_bank = (i_op == MPS_OP_LOAD_BANK) ? src : o_ram_bank_reg;
  assign next_scratch =
    (i_op == MPS_OP_LOAD_SCRATCH) ? src : o_scratch_page_reg;
  // reserved bit is stored as zero and reads back as zero
  assign next_ind = (i_op == MPS_OP_LOAD_IND_PAGE) ?
    {1'b0, src[MPS_IND_SEL_W-1:0]} : o_indirect_page_reg; // RULE13

  // return stack, pointer wraps so the oldest slot is overwritten
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      stack_ptr <= MPS_PTR_RESET;
      o_pop_context <= MPS_CTX_RESET;
    end else if (do_push) begin
      stack_ptr <= stack_ptr + 4'h1; // RULE1 RULE4
    end else if (do_pop) begin
      stack_ptr <= top_idx; // RULE3
      o_pop_context <= top_entry[MPS_STACK_W-1:MPS_PC_W];
    end
  end

  // stack storage has no reset; unwritten slots are never popped usefully
  always_ff @(posedge i_clock) begin
    if (do_push) begin
      stack_mem[stack_ptr] <= {i_context, push_pc}; // RULE1 RULE2
    end
  end

  // slot of the lookup index nibble that a table load aims at
  wire logic [4:0] tab_ofs = i_op - MPS_OP_LOAD_TAB0;
  wire logic [1:0] tab_sel = tab_ofs[1:0];

  // lookup index nibbles, loaded one at a time from the register operand, never an immediate
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      for (int k = 0; k < 4; k++) begin
        tab_nib[k] <= MPS_REG_RESET;
      end
    end else if (is_load_tab && !tab_refused) begin
      tab_nib[tab_sel] <= i_operand; // RULE9
    end
  end
  assign o_table_addr = {tab_nib[3], tab_nib[2], tab_nib[1], tab_nib[0]};

  // page and bank selection registers with their derived bases
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      o_program_page_reg <= MPS_REG_RESET;
      o_indirect_page_reg <= MPS_REG_RESET;
      o_scratch_page_reg <= MPS_REG_RESET;
      o_ram_bank_reg <= MPS_REG_RESET;
      o_bank_base <= '0;
      o_indirect_base <= '0;
      o_wr_base <= '0;
    end else begin
      if (i_op == MPS_OP_LOAD_PROG_PAGE) begin
        o_program_page_reg <= src; // RULE6
      end
      o_indirect_page_reg <= next_ind;
      o_scratch_page_reg <= next_scratch; // RULE15
      o_ram_bank_reg <= next_bank; // RULE11
      o_bank_base <= next_bank_base;
      o_indirect_base <= next_ind_base;
      o_wr_base <= next_wr_base;
    end
  end

  // program counter, accumulator, flags and result port
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      o_pc <= MPS_PC_RESET;
      o_acc <= MPS_REG_RESET;
      o_carry_flag <= 1'b0;
      o_zero_flag <= 1'b0;
      o_result <= MPS_REG_RESET;
      o_result_valid <= 1'b0;
      o_illegal <= 1'b0;
    end else begin
      o_pc <= next_pc;
      o_acc <= next_acc;
      o_carry_flag <= next_carry;
      o_zero_flag <= next_zero;
      o_result <= next_result;
      o_result_valid <= next_result_valid;
      o_illegal <= refuse || tab_refused; // RULE16
    end
  end

endmodule // mps_core

// ---- rtl/mps_pkg.sv ----
// constants, operation and condition codes for the paging and stack core
// assumes a single 125 MHz system clock shared by every user of the package
package mps_pkg;
  localparam int MPS_PC_W = 14;
  localparam int MPS_OFS_W = 11;
  localparam int MPS_PAGE_W = MPS_PC_W - MPS_OFS_W;
  localparam int MPS_ROM_WORDS = 16384;
  localparam int MPS_PAGE_WORDS = 2048;
  localparam int MPS_STACK_DEPTH = 16;
  localparam int MPS_STACK_W = 49;
  localparam int MPS_CTX_W = MPS_STACK_W - MPS_PC_W;
  localparam int MPS_PTR_W = 4;
  localparam int MPS_NIB_W = 4;
  localparam int MPS_TAB_W = 16;
  localparam int MPS_TABLE_ELEMS = 65536;
  localparam int MPS_RAM_NIBBLES = 2048;
  localparam int MPS_BANK_NIBBLES = 128;
  localparam int MPS_RAM_ADDR_W = 11;
  localparam int MPS_IND_SEL_W = 3;
  localparam int MPS_IND_PAGE_NIBBLES = 16;
  localparam int MPS_WR_ADDR_W = 8;
  localparam int MPS_WR_PAGE_NIBBLES = 16;
  // field positions
  localparam int MPS_IND_RSVD_BIT = 3;
  localparam int MPS_BANK_LSB = 7;
  localparam int MPS_IND_LSB = 4;
  localparam int MPS_WR_LSB = 4;
  // reset values
  localparam logic [MPS_PC_W-1:0] MPS_PC_RESET = 14'h0000;
  localparam logic [MPS_NIB_W-1:0] MPS_REG_RESET = 4'h0;
  localparam logic [MPS_PTR_W-1:0] MPS_PTR_RESET = 4'h0;
  localparam logic [MPS_CTX_W-1:0] MPS_CTX_RESET = 35'h0;
  localparam logic [MPS_TAB_W-1:0] MPS_TAB_RESET = 16'h0000;
  // in-page steps of the program counter
  localparam logic [MPS_OFS_W-1:0] MPS_STEP_ONE = 11'h001;
  localparam logic [MPS_OFS_W-1:0] MPS_STEP_TWO = 11'h002;

  typedef enum logic [4:0] {
    MPS_OP_IDLE = 5'h00, MPS_OP_STEP = 5'h01,
    MPS_OP_LOAD_PROG_PAGE = 5'h02, MPS_OP_LOAD_IND_PAGE = 5'h03,
    MPS_OP_LOAD_SCRATCH = 5'h04, MPS_OP_LOAD_BANK = 5'h05,
    MPS_OP_LOAD_TAB0 = 5'h06, MPS_OP_LOAD_TAB1 = 5'h07,
    MPS_OP_LOAD_TAB2 = 5'h08, MPS_OP_LOAD_TAB3 = 5'h09,
    MPS_OP_JUMP = 5'h0A, MPS_OP_CALL = 5'h0B, MPS_OP_INT_ENTRY = 5'h0C,
    MPS_OP_RETURN = 5'h0D, MPS_OP_BRANCH_JUMP = 5'h0E,
    MPS_OP_BRANCH_SKIP = 5'h0F, MPS_OP_TABLE_READ = 5'h10,
    MPS_OP_READ_CARRY = 5'h11, MPS_OP_AND = 5'h12, MPS_OP_XOR = 5'h13,
    MPS_OP_OR = 5'h14, MPS_OP_ADD = 5'h15, MPS_OP_ADC = 5'h16,
    MPS_OP_SUB = 5'h17, MPS_OP_SBC = 5'h18, MPS_OP_INC = 5'h19,
    MPS_OP_DEC = 5'h1A, MPS_OP_RRC = 5'h1B, MPS_OP_RLC = 5'h1C,
    MPS_OP_SHRC = 5'h1D, MPS_OP_SHLC = 5'h1E, MPS_OP_LOAD_ACC = 5'h1F
  } mps_op_t;

  typedef enum logic [3:0] {
    MPS_C_BIT0 = 4'h0, MPS_C_BIT1 = 4'h1, MPS_C_BIT2 = 4'h2,
    MPS_C_BIT3 = 4'h3, MPS_C_ZERO = 4'h4, MPS_C_NONZERO = 4'h5,
    MPS_C_CARRY = 4'h6, MPS_C_NOCARRY = 4'h7, MPS_C_DEC_ZERO = 4'h8,
    MPS_C_DEC_NONZERO = 4'h9
  } mps_cond_t;
endpackage

// ---- tb/mps_core_asserts.sv ----
// checker for the paging and stack core, sees the core's ports only
// assumes one clock and an asynchronous active-high reset
module mps_core_asserts
  import mps_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_reset,
  input wire mps_op_t i_op,
  input wire mps_cond_t i_cond,
  input wire logic [3:0] i_operand,
  input wire logic [3:0] i_imm,
  input wire logic i_use_imm,
  input wire logic i_operand_is_wr,
  input wire logic [10:0] i_offset,
  input wire logic [13:0] i_vector,
  input wire logic [34:0] i_context,
  input wire logic [3:0] i_table_data,
  input wire logic [13:0] o_pc,
  input wire logic [34:0] o_pop_context,
  input wire logic [3:0] o_program_page_reg,
  input wire logic [3:0] o_indirect_page_reg,
  input wire logic [3:0] o_scratch_page_reg,
  input wire logic [3:0] o_ram_bank_reg,
  input wire logic [3:0] o_acc,
  input wire logic o_carry_flag,
  input wire logic o_zero_flag,
  input wire logic [15:0] o_table_addr,
  input wire logic [10:0] o_bank_base,
  input wire logic [10:0] o_indirect_base,
  input wire logic [7:0] o_wr_base,
  input wire logic [3:0] o_result,
  input wire logic o_result_valid,
  input wire logic o_illegal
);
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_reset);
  // alu-class operations and the accumulator load, and their refused immediate form
  wire logic alu_op = (i_op >= MPS_OP_AND);
  wire logic bad_imm = alu_op && i_use_imm && !i_operand_is_wr;
  // a call straight followed by its return
  sequence call_then_ret;
    (i_op == MPS_OP_CALL) ##1 (i_op == MPS_OP_RETURN);
  endsequence
  stack_pop_a: assert property (call_then_ret |=>
    o_pc == {$past(o_pc[13:11], 2), $past(o_pc[10:0], 2) + 11'h001} &&
    o_pop_context == $past(i_context, 2))
    else $error("return did not restore the called-from address");
  jump_target_a: assert property (
    (i_op inside {MPS_OP_JUMP, MPS_OP_CALL}) |=>
    o_pc == {$past(o_program_page_reg[2:0]), $past(i_offset)})
    else $error("jump target not page register above offset");
  int_vector_a: assert property (
    (i_op == MPS_OP_INT_ENTRY) |=> o_pc == $past(i_vector))
    else $error("interrupt entry did not load the vector");
  branch_page_a: assert property (
    (i_op inside {MPS_OP_BRANCH_JUMP, MPS_OP_BRANCH_SKIP}) |=>
    o_pc[13:11] == $past(o_pc[13:11]))
    else $error("branch left its page");
  table_read_a: assert property (
    (i_op == MPS_OP_TABLE_READ) |=>
    o_result_valid && o_result == $past(i_table_data))
    else $error("table read result wrong");
  table_ptr_a: assert property (
    (i_op == MPS_OP_LOAD_TAB3 && !i_use_imm) |=>
    o_table_addr[15:12] == $past(i_operand))
    else $error("top table pointer nibble not loaded");
  base_map_a: assert property (
    o_bank_base == {o_ram_bank_reg, 7'h00} &&
    o_wr_base == {o_scratch_page_reg, 4'h0})
    else $error("bank or working register base wrong");
  ind_page_a: assert property (
    o_indirect_base == {o_ram_bank_reg, o_indirect_page_reg[2:0], 4'h0} &&
    !o_indirect_page_reg[3])
    else $error("indirect page base wrong");
  carry_read_a: assert property (
    (i_op == MPS_OP_READ_CARRY) |=>
    o_result_valid && o_result == {3'h0, $past(o_carry_flag)})
    else $error("carry read result wrong");
  imm_refuse_a: assert property (
    bad_imm |=> o_illegal && $stable(o_acc))
    else $error("immediate against data memory not refused");
  zero_flag_a: assert property (
    (alu_op && !bad_imm) |=> o_zero_flag == (o_acc == 4'h0))
    else $error("zero flag does not follow accumulator");
endmodule // mps_core_asserts

bind mps_core mps_core_asserts u_asserts (
  .i_clock, .i_reset, .i_op, .i_cond, .i_operand, .i_imm, .i_use_imm,
  .i_operand_is_wr, .i_offset, .i_vector, .i_context, .i_table_data,
  .o_pc, .o_pop_context, .o_program_page_reg, .o_indirect_page_reg,
  .o_scratch_page_reg, .o_ram_bank_reg, .o_acc, .o_carry_flag,
  .o_zero_flag, .o_table_addr, .o_bank_base, .o_indirect_base,
  .o_wr_base, .o_result, .o_result_valid, .o_illegal
);

// ---- tb/testbench.sv ----
// self-checking bench for the paging and stack core
// assumes one operation per cycle, effects visible one edge later
module testbench
  import mps_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clock = 1'b0;
  logic i_reset = 1'b1;
  mps_op_t i_op = MPS_OP_IDLE;
  mps_cond_t i_cond = MPS_C_BIT0;
  logic [3:0] i_operand = 4'h0, i_imm = 4'h0, i_table_data = 4'h0;
  logic i_use_imm = 1'b0, i_operand_is_wr = 1'b0;
  logic [10:0] i_offset = 11'h000;
  logic [13:0] i_vector = 14'h0000, o_pc, pc_m;
  logic [34:0] i_context = 35'h0, o_pop_context;
  logic [3:0] o_program_page_reg, o_indirect_page_reg, o_scratch_page_reg;
  logic [3:0] o_ram_bank_reg, o_acc, o_result;
  logic o_carry_flag, o_zero_flag, o_result_valid, o_illegal;
  logic [15:0] o_table_addr;
  logic [10:0] o_bank_base, o_indirect_base;
  logic [7:0] o_wr_base;
  int fails = 0;
  int comparisons = 0;
  mps_core dut (
    .i_clock, .i_reset, .i_op, .i_cond, .i_operand, .i_imm, .i_use_imm,
    .i_operand_is_wr, .i_offset, .i_vector, .i_context, .i_table_data,
    .o_pc, .o_pop_context, .o_program_page_reg, .o_indirect_page_reg,
    .o_scratch_page_reg, .o_ram_bank_reg, .o_acc, .o_carry_flag,
    .o_zero_flag, .o_table_addr, .o_bank_base, .o_indirect_base,
    .o_wr_base, .o_result, .o_result_valid, .o_illegal
  );
  // 125 MHz clock
  always #4 i_clock = ~i_clock;
  task automatic chk(input string n, input logic [47:0] e, g);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s expected %0h seen %0h", n, e, g);
    end
  endtask
  // present one operation and let its edge land
  task automatic cyc(input mps_op_t o);
    i_op = o;
    @(posedge i_clock);
    #1;
  endtask
  task automatic t_jump();
    for (int p = 0; p < 8; p++) begin
      i_imm = 4'(p);
      i_use_imm = 1'b1;
      cyc(MPS_OP_LOAD_PROG_PAGE);
      i_use_imm = 1'b0;
      i_offset = 11'h7FF;
      cyc(MPS_OP_JUMP);
      chk("jump pc", {p[2:0], 11'h7FF}, o_pc);
    end
    cyc(MPS_OP_STEP);
    chk("page wrap pc", 14'h3800, o_pc);
    cyc(MPS_OP_IDLE);
    chk("idle pc", 14'h3800, o_pc);
    $display("test jump done");
  endtask
  task automatic t_stack();
    logic [13:0] ret [17];
    int j;
    i_imm = 4'h1;
    i_use_imm = 1'b1;
    cyc(MPS_OP_LOAD_PROG_PAGE);
    i_use_imm = 1'b0;
    i_offset = 11'h100;
    i_vector = 14'h0014;
    cyc(MPS_OP_JUMP);
    cyc(MPS_OP_INT_ENTRY);
    chk("vector pc", 14'h0014, o_pc);
    cyc(MPS_OP_RETURN);
    chk("interrupt return pc", 14'h0900, o_pc);
    pc_m = 14'h0900;
    for (int k = 0; k < 17; k++) begin
      ret[k] = {pc_m[13:11], pc_m[10:0] + 11'h001};
      i_offset = 11'h200 + 11'(k);
      i_context = 35'h400000100 + 35'(k);
      cyc(MPS_OP_CALL);
      pc_m = {3'h1, i_offset};
      chk("call pc", pc_m, o_pc);
    end
    for (int k = 16; k >= 0; k--) begin
      j = (k > 0) ? k : 16;
      cyc(MPS_OP_RETURN);
      chk("pop pc", ret[j], o_pc);
      chk("pop context", 35'h400000100 + 35'(j), o_pop_context);
    end
    $display("test stack done");
  endtask
  task automatic br(input mps_op_t o, mps_cond_t c, logic [3:0] v, logic t);
    i_cond = c;
    i_operand = v;
    cyc(o);
    if (o == MPS_OP_BRANCH_JUMP && t) pc_m = {pc_m[13:11], i_offset};
    else pc_m = {pc_m[13:11], pc_m[10:0] + (t ? 11'h002 : 11'h001)};
    chk("branch pc", pc_m, o_pc);
  endtask
  task automatic t_branch();
    i_imm = 4'h2;
    i_use_imm = 1'b1;
    cyc(MPS_OP_LOAD_PROG_PAGE);
    i_use_imm = 1'b0;
    i_offset = 11'h7FE;
    cyc(MPS_OP_JUMP);
    pc_m = 14'h17FE;
    br(MPS_OP_BRANCH_JUMP, MPS_C_BIT0, 4'h1, 1'b1);
    br(MPS_OP_BRANCH_JUMP, MPS_C_BIT1, 4'hD, 1'b0);
    br(MPS_OP_BRANCH_SKIP, MPS_C_BIT2, 4'h4, 1'b1);
    br(MPS_OP_BRANCH_SKIP, MPS_C_BIT3, 4'h7, 1'b0);
    br(MPS_OP_BRANCH_SKIP, MPS_C_DEC_ZERO, 4'h1, 1'b1);
    chk("dec zero", 7'h43,
      {o_result_valid, o_result, o_zero_flag, o_carry_flag});
    br(MPS_OP_BRANCH_JUMP, MPS_C_ZERO, 4'h0, 1'b1);
    br(MPS_OP_BRANCH_JUMP, MPS_C_NONZERO, 4'h0, 1'b0);
    br(MPS_OP_BRANCH_SKIP, MPS_C_CARRY, 4'h0, 1'b1);
    br(MPS_OP_BRANCH_SKIP, MPS_C_NOCARRY, 4'h0, 1'b0);
    br(MPS_OP_BRANCH_SKIP, MPS_C_DEC_NONZERO, 4'h0, 1'b1);
    chk("dec nonzero", 7'h7C,
      {o_result_valid, o_result, o_zero_flag, o_carry_flag});
    $display("test branch done");
  endtask
  // e holds illegal, carry, zero and accumulator
  task automatic alu(input mps_op_t o, logic [3:0] s, logic u, w,
    logic [6:0] e);
    i_operand = s;
    i_imm = s;
    i_use_imm = u;
    i_operand_is_wr = w;
    cyc(o);
    chk("alu state", e,
      {o_illegal, o_carry_flag, o_zero_flag, o_acc});
  endtask
  task automatic t_alu();
    alu(MPS_OP_LOAD_ACC, 4'h9, 0, 0, 7'h09);
    alu(MPS_OP_ADD, 4'h8, 0, 0, 7'h21);
    alu(MPS_OP_ADC, 4'h5, 0, 0, 7'h07);
    alu(MPS_OP_SUB, 4'h7, 0, 0, 7'h30);
    alu(MPS_OP_SBC, 4'h1, 0, 0, 7'h0F);
    alu(MPS_OP_AND, 4'h3, 0, 0, 7'h03);
    alu(MPS_OP_OR, 4'hC, 0, 0, 7'h0F);
    alu(MPS_OP_XOR, 4'hF, 0, 0, 7'h10);
    alu(MPS_OP_INC, 4'hF, 0, 0, 7'h30);
    alu(MPS_OP_DEC, 4'h0, 0, 0, 7'h0F);
    alu(MPS_OP_RRC, 4'h5, 0, 0, 7'h22);
    alu(MPS_OP_RLC, 4'h8, 0, 0, 7'h21);
    alu(MPS_OP_SHRC, 4'h3, 0, 0, 7'h21);
    alu(MPS_OP_SHLC, 4'h4, 0, 0, 7'h08);
    alu(MPS_OP_ADD, 4'h1, 1, 0, 7'h48);
    alu(MPS_OP_ADD, 4'h1, 1, 1, 7'h09);
    alu(MPS_OP_ADD, 4'h7, 1, 1, 7'h30);
    cyc(MPS_OP_READ_CARRY);
    chk("carry read", 5'h11, {o_result_valid, o_result});
    $display("test alu done");
  endtask
  task automatic t_paging();
    i_imm = 4'hF;
    i_use_imm = 1'b1;
    cyc(MPS_OP_LOAD_BANK);
    cyc(MPS_OP_LOAD_IND_PAGE);
    cyc(MPS_OP_LOAD_SCRATCH);
    chk("bank base", 11'h780, o_bank_base);
    chk("indirect base", 11'h7F0, o_indirect_base);
    chk("indirect page", 4'h7, o_indirect_page_reg);
    chk("wr base", 8'hF0, o_wr_base);
    i_use_imm = 1'b0;
    i_operand = 4'h1;
    cyc(MPS_OP_LOAD_BANK);
    cyc(MPS_OP_LOAD_SCRATCH);
    chk("bases", 30'h0400F010,
      {o_bank_base, o_indirect_base, o_wr_base});
    $display("test paging done");
  endtask
  task automatic t_table();
    i_use_imm = 1'b0;
    for (int n = 0; n < 4; n++) begin
      i_operand = 4'(n + 1);
      cyc(mps_op_t'(5'(MPS_OP_LOAD_TAB0) + 5'(n)));
    end
    chk("table addr", 16'h4321, o_table_addr);
    i_table_data = 4'hA;
    cyc(MPS_OP_TABLE_READ);
    chk("table read", 5'h1A, {o_result_valid, o_result});
    i_use_imm = 1'b1;
    cyc(MPS_OP_LOAD_TAB0);
    chk("table refuse", 17'h14321, {o_illegal, o_table_addr});
    $display("test table done");
  endtask
  task automatic results();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (4) @(posedge i_clock);
    #1;
    i_reset = 1'b0;
    chk("reset state", 38'h0, {o_pc, o_acc, o_ram_bank_reg, o_table_addr});
    t_jump();
    t_stack();
    t_branch();
    t_alu();
    t_paging();
    t_table();
    results();
  end
  // run time limit
  initial begin
    #100000;
    fails++;
    results();
  end
endmodule // testbench
